/* File: decrc_regs.svh */
// Register offsets, field positions and reset values of the display top control bank.
// Included by the package and decrc_top; holds definitions only.
`ifndef DECRC_REGS_SVH
`define DECRC_REGS_SVH

`define DECRC_OFF_CORE_CLOCK_GATE      12'h000
`define DECRC_OFF_BUS_CLOCK_GATE       12'h004
`define DECRC_OFF_RESET_RELEASE        12'h008
`define DECRC_OFF_CLOCK_DIVIDER        12'h00C
`define DECRC_OFF_OUTPUT_ROUTE         12'h010
`define DECRC_OFF_DRAM_CMD_DEPTH       12'h014
`define DECRC_OFF_DEINTERLACE_SEL      12'h01C

`define DECRC_RESET_VALUE              32'h0000_0000

`define DECRC_UNIT_FIRST               0
`define DECRC_UNIT_SECOND              1
`define DECRC_UNIT_WB                  2
`define DECRC_UNIT_ROT                 3

`define DECRC_DIV_FIELD_W              4
`define DECRC_CMD_WB_LSB               16
`define DECRC_CMD_SECOND_LSB           4
`define DECRC_CMD_FIRST_LSB            0
`define DECRC_DI_SECOND_BIT            4
`define DECRC_DI_FIRST_BIT             0
`define DECRC_ROUTE_SWAP_BIT           0

`define DECRC_ENGINE_BASE              32'h0100_0000
`define DECRC_WIN_TOP                  24'h00_0000
`define DECRC_WIN_WB                   24'h01_0000
`define DECRC_WIN_ROT                  24'h02_0000
`define DECRC_WIN_DI                   24'h03_0000
`define DECRC_WIN_FIRST                24'h10_0000
`define DECRC_WIN_SECOND               24'h20_0000
`define DECRC_SIZE_64K                 24'h01_0000
`define DECRC_SIZE_128K                24'h02_0000
`define DECRC_SIZE_1M                  24'h10_0000

`endif

/* File: decrc_pkg.sv */
// Types shared by the display top control bank modules.
// Assumes decrc_regs.svh is on the include path.
`include "decrc_regs.svh"

package decrc_pkg;

    // Sub-region selected by an engine address.
    typedef enum logic [2:0] {
        DECRC_REGION_NONE   = 3'b000,
        DECRC_REGION_TOP    = 3'b001,
        DECRC_REGION_WB     = 3'b010,
        DECRC_REGION_ROT    = 3'b011,
        DECRC_REGION_DI     = 3'b100,
        DECRC_REGION_FIRST  = 3'b101,
        DECRC_REGION_SECOND = 3'b110
    } decrc_region_t;

endpackage : decrc_pkg

/* File: decrc_clk_div.sv */
// One divided-rate enable for a sub-unit processing clock.
// Assumes a single clock; the output is a one-cycle enable pulse every (div+1) cycles.
`timescale 1ns/10ps
`default_nettype none

module decrc_clk_div #(
    parameter int DIV_W = 4
) (
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    input  wire logic [DIV_W-1:0] div_i,
    input  wire logic             run_i,
    output logic                  tick_o
);

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic             tick_reg;
    logic             tick_next;

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!run_i) begin
            cnt_next = '0;
        end else if (cnt_reg >= div_i) begin
            // Shrinking the field mid-count restarts cleanly instead of wrapping.
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_o = tick_reg;

endmodule : decrc_clk_div

`default_nettype wire

/* File: decrc_addr_decode.sv */
// Decodes an engine bus address into the sub-region that owns it.
// Assumes the address is already registered in the caller's clock domain.
`timescale 1ns/10ps
`default_nettype none

module decrc_addr_decode
    import decrc_pkg::*;
#(
    parameter bit HAS_ROTATOR = 1'b1
) (
    input  wire logic [31:0] addr_i,
    output decrc_region_t    region_o
);

    function automatic logic in_win(input logic [23:0] off,
                                    input logic [23:0] base,
                                    input logic [23:0] size);
        in_win = (off >= base) && (off < (base + size));
    endfunction : in_win

    logic [23:0] off;
    logic        in_engine;

    // The engine owns a 4M base region; the low 24 bits are the offset in it.
    assign in_engine = (addr_i[31:22] == 10'(`DECRC_ENGINE_BASE >> 22));
    assign off       = addr_i[23:0];

    always_comb begin
        region_o = DECRC_REGION_NONE;
        if (in_engine) begin
            if (in_win(off, `DECRC_WIN_TOP, `DECRC_SIZE_64K)) begin
                region_o = DECRC_REGION_TOP;
            end else if (in_win(off, `DECRC_WIN_WB, `DECRC_SIZE_64K)) begin
                region_o = DECRC_REGION_WB;
            end else if (HAS_ROTATOR && in_win(off, `DECRC_WIN_ROT, `DECRC_SIZE_64K)) begin
                region_o = DECRC_REGION_ROT;
            end else if (HAS_ROTATOR && in_win(off, `DECRC_WIN_DI, `DECRC_SIZE_128K)) begin
                region_o = DECRC_REGION_DI;
            end else if (in_win(off, `DECRC_WIN_FIRST, `DECRC_SIZE_1M)) begin
                region_o = DECRC_REGION_FIRST;
            end else if (in_win(off, `DECRC_WIN_SECOND, `DECRC_SIZE_1M)) begin
                region_o = DECRC_REGION_SECOND;
            end else begin
                region_o = DECRC_REGION_NONE;
            end
        end
    end

endmodule : decrc_addr_decode

`default_nettype wire

/* File: decrc_top.sv */
// Top control register bank of the display composition engine: clock gates,
// sub-unit reset release, clock dividers, output routing, DRAM command depth
// and deinterlace source select.
// Assumes a single bus clock and a plain strobe register port on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "decrc_regs.svh"

// Functional notes
// - processing clock gate per unit, 1 passes
// - bus clock gate per unit, 1 passes
// - reset bit 0 holds unit, 1 releases
// - four 4-bit divider fields, upper reserved
// - route bit swaps compositors between controllers
// - command depth fields allow about N+2
// - deinterlace bit picks scaler input source
// - engine address windows decoded per sub-unit
// - reduced variant drops rotator and extras
module decrc_top
    import decrc_pkg::*;
#(
    parameter bit HAS_ROTATOR = 1'b1,
    parameter int DIV_W       = `DECRC_DIV_FIELD_W
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic [31:0] eng_addr_i,
    output decrc_region_t    eng_region_o,
    output logic      [3:0]  proc_clock_en_o,
    output logic      [3:0]  bus_clock_pass_o,
    output logic      [3:0]  reset_release_o,
    output logic             timing_controller_a_src_o,
    output logic             timing_controller_b_src_o,
    output logic      [3:0]  first_compositor_command_depth_o,
    output logic      [3:0]  second_compositor_command_depth_o,
    output logic      [3:0]  writeback_command_depth_o,
    output logic             first_compositor_deinterlace_select_o,
    output logic             second_compositor_deinterlace_select_o
);

    // =========================================================================
    // Field masks per variant
    // =========================================================================
    localparam logic [3:0]  UNIT_MASK = HAS_ROTATOR ? 4'hF : 4'h7;
    localparam logic [31:0] GATE_MASK = {28'h0, UNIT_MASK};
    localparam logic [31:0] DIV_MASK  = HAS_ROTATOR ? 32'h0000_FFFF : 32'h0000_0FFF;
    localparam logic [31:0] ROUTE_MASK = 32'h0000_0001;
    localparam logic [31:0] CMD_MASK  = 32'h000F_00FF;
    localparam logic [31:0] DI_MASK   = 32'h0000_0011;

    // =========================================================================
    // Register state
    // =========================================================================
    logic [31:0] core_clock_gate_reg;
    logic [31:0] core_clock_gate_next;
    logic [31:0] bus_clock_gate_reg;
    logic [31:0] bus_clock_gate_next;
    logic [31:0] subunit_reset_release_reg;
    logic [31:0] subunit_reset_release_next;
    logic [31:0] core_clock_divider_reg;
    logic [31:0] core_clock_divider_next;
    logic [31:0] output_route_select_reg;
    logic [31:0] output_route_select_next;
    logic [31:0] dram_command_depth_reg;
    logic [31:0] dram_command_depth_next;
    logic [31:0] deinterlace_source_select_reg;
    logic [31:0] deinterlace_source_select_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        core_clock_gate_next           = core_clock_gate_reg;
        bus_clock_gate_next            = bus_clock_gate_reg;
        subunit_reset_release_next     = subunit_reset_release_reg;
        core_clock_divider_next        = core_clock_divider_reg;
        output_route_select_next       = output_route_select_reg;
        dram_command_depth_next        = dram_command_depth_reg;
        deinterlace_source_select_next = deinterlace_source_select_reg;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `DECRC_OFF_CORE_CLOCK_GATE: begin
                    core_clock_gate_next = reg_wdata_i & GATE_MASK;
                end
                `DECRC_OFF_BUS_CLOCK_GATE: begin
                    bus_clock_gate_next = reg_wdata_i & GATE_MASK;
                end
                `DECRC_OFF_RESET_RELEASE: begin
                    subunit_reset_release_next = reg_wdata_i & GATE_MASK;
                end
                `DECRC_OFF_CLOCK_DIVIDER: begin
                    core_clock_divider_next = reg_wdata_i & DIV_MASK;
                end
                `DECRC_OFF_OUTPUT_ROUTE: begin
                    output_route_select_next = reg_wdata_i & ROUTE_MASK;
                end
                `DECRC_OFF_DRAM_CMD_DEPTH: begin
                    if (HAS_ROTATOR) begin
                        dram_command_depth_next = reg_wdata_i & CMD_MASK;
                    end
                end
                `DECRC_OFF_DEINTERLACE_SEL: begin
                    if (HAS_ROTATOR) begin
                        deinterlace_source_select_next = reg_wdata_i & DI_MASK;
                    end
                end
                default: begin
                    core_clock_gate_next = core_clock_gate_reg;
                end
            endcase
        end
    end

    // Read data is valid only in the cycle after the strobe; zero otherwise.
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `DECRC_OFF_CORE_CLOCK_GATE:   rdata_next = core_clock_gate_reg;
                `DECRC_OFF_BUS_CLOCK_GATE:    rdata_next = bus_clock_gate_reg;
                `DECRC_OFF_RESET_RELEASE:     rdata_next = subunit_reset_release_reg;
                `DECRC_OFF_CLOCK_DIVIDER:     rdata_next = core_clock_divider_reg;
                `DECRC_OFF_OUTPUT_ROUTE:      rdata_next = output_route_select_reg;
                `DECRC_OFF_DRAM_CMD_DEPTH:    rdata_next = dram_command_depth_reg;
                `DECRC_OFF_DEINTERLACE_SEL:   rdata_next = deinterlace_source_select_reg;
                default:                      rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            core_clock_gate_reg           <= `DECRC_RESET_VALUE;
            bus_clock_gate_reg            <= `DECRC_RESET_VALUE;
            subunit_reset_release_reg     <= `DECRC_RESET_VALUE;
            core_clock_divider_reg        <= `DECRC_RESET_VALUE;
            output_route_select_reg       <= `DECRC_RESET_VALUE;
            dram_command_depth_reg        <= `DECRC_RESET_VALUE;
            deinterlace_source_select_reg <= `DECRC_RESET_VALUE;
            rdata_reg                     <= 32'h0000_0000;
        end else begin
            core_clock_gate_reg           <= core_clock_gate_next;
            bus_clock_gate_reg            <= bus_clock_gate_next;
            subunit_reset_release_reg     <= subunit_reset_release_next;
            core_clock_divider_reg        <= core_clock_divider_next;
            output_route_select_reg       <= output_route_select_next;
            dram_command_depth_reg        <= dram_command_depth_next;
            deinterlace_source_select_reg <= deinterlace_source_select_next;
            rdata_reg                     <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // =========================================================================
    // Divided processing-clock enables
    // =========================================================================
    logic [3:0] tick;

    for (genvar u = 0; u < 4; u++) begin : g_div
        decrc_clk_div #(
            .DIV_W (DIV_W)
        ) u_div (
            .core_clk_i (core_clk_i),
            .srst_i     (srst_i),
            .div_i      (core_clock_divider_reg[u*4 +: DIV_W]),
            .run_i      (core_clock_gate_reg[u]),
            .tick_o     (tick[u])
        );
    end

    // =========================================================================
    // Registered control outputs
    // =========================================================================
    logic [3:0]    proc_en_reg;
    logic [3:0]    proc_en_next;
    logic [3:0]    bus_pass_reg;
    logic [3:0]    release_reg;
    logic          route_a_reg;
    logic          route_b_reg;
    logic [3:0]    cmd_first_reg;
    logic [3:0]    cmd_second_reg;
    logic [3:0]    cmd_wb_reg;
    logic          di_first_reg;
    logic          di_second_reg;
    decrc_region_t region_comb;
    decrc_region_t region_reg;
    logic          swap;

    assign swap = output_route_select_reg[`DECRC_ROUTE_SWAP_BIT];

    always_comb begin
        proc_en_next = tick & core_clock_gate_reg[3:0] & UNIT_MASK;
    end

    decrc_addr_decode #(
        .HAS_ROTATOR (HAS_ROTATOR)
    ) u_decode (
        .addr_i   (eng_addr_i),
        .region_o (region_comb)
    );

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            proc_en_reg    <= 4'h0;
            bus_pass_reg   <= 4'h0;
            release_reg    <= 4'h0;
            route_a_reg    <= 1'b0;
            route_b_reg    <= 1'b1;
            cmd_first_reg  <= 4'h0;
            cmd_second_reg <= 4'h0;
            cmd_wb_reg     <= 4'h0;
            di_first_reg   <= 1'b0;
            di_second_reg  <= 1'b0;
            region_reg     <= DECRC_REGION_NONE;
        end else begin
            proc_en_reg    <= proc_en_next;
            bus_pass_reg   <= bus_clock_gate_reg[3:0];
            release_reg    <= subunit_reset_release_reg[3:0];
            route_a_reg    <= swap;
            route_b_reg    <= ~swap;
            cmd_first_reg  <= dram_command_depth_reg[`DECRC_CMD_FIRST_LSB +: 4];
            cmd_second_reg <= dram_command_depth_reg[`DECRC_CMD_SECOND_LSB +: 4];
            cmd_wb_reg     <= dram_command_depth_reg[`DECRC_CMD_WB_LSB +: 4];
            di_first_reg   <= deinterlace_source_select_reg[`DECRC_DI_FIRST_BIT];
            di_second_reg  <= deinterlace_source_select_reg[`DECRC_DI_SECOND_BIT];
            region_reg     <= region_comb;
        end
    end

    assign proc_clock_en_o                        = proc_en_reg;
    assign bus_clock_pass_o                       = bus_pass_reg;
    assign reset_release_o                        = release_reg;
    assign timing_controller_a_src_o              = route_a_reg;
    assign timing_controller_b_src_o              = route_b_reg;
    assign first_compositor_command_depth_o       = cmd_first_reg;
    assign second_compositor_command_depth_o      = cmd_second_reg;
    assign writeback_command_depth_o              = cmd_wb_reg;
    assign first_compositor_deinterlace_select_o  = di_first_reg;
    assign second_compositor_deinterlace_select_o = di_second_reg;
    assign eng_region_o                           = region_reg;

endmodule : decrc_top

`default_nettype wire

/* File: decrc_chk.sv */
// Concurrent checks on the ports of the display top control bank.
// Assumes one bus clock, a synchronous active-high reset and HAS_ROTATOR set.
`timescale 1ns/10ps
`default_nettype none

module decrc_chk (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_rdata_o,
    input  wire logic [3:0]  proc_clock_en_o,
    input  wire logic [3:0]  bus_clock_pass_o,
    input  wire logic [3:0]  reset_release_o,
    input  wire logic        timing_controller_a_src_o,
    input  wire logic        timing_controller_b_src_o,
    input  wire logic [3:0]  first_compositor_command_depth_o,
    input  wire logic [3:0]  second_compositor_command_depth_o,
    input  wire logic [3:0]  writeback_command_depth_o,
    input  wire logic        first_compositor_deinterlace_select_o,
    input  wire logic        second_compositor_deinterlace_select_o
);
    // ==========================================================
    // Shadow of the register file, kept from observed writes
    logic        hit;
    logic        chg;
    logic [2:0]  idx;
    logic [31:0] rd_exp;
    logic [31:0] sh_reg [8];
    logic [4:0]  gap_reg;
    logic [4:0]  gap_next;
    logic [1:0]  cln_reg;
    logic [1:0]  cln_next;

    function automatic logic [31:0] fmask(input logic [2:0] i);
        case (i)
            3'h0, 3'h1, 3'h2: fmask = 32'h0000_000F;
            3'h3:             fmask = 32'h0000_FFFF;
            3'h4:             fmask = 32'h0000_0001;
            3'h5:             fmask = 32'h000F_00FF;
            3'h7:             fmask = 32'h0000_0011;
            default:          fmask = 32'h0000_0000;
        endcase
    endfunction : fmask

    assign idx    = reg_addr_i[4:2];
    assign hit    = (reg_addr_i[11:5] == 7'h00) && (reg_addr_i[1:0] == 2'h0) && (idx != 3'h6);
    assign rd_exp = hit ? sh_reg[idx] : 32'h0000_0000;
    assign chg    = reg_wr_i && hit && ((idx == 3'h0) || (idx == 3'h3));

    // Spacing is judged only after three pulses, so stale pulses from the
    // divider pipeline right after a gate or divider write are not blamed.
    always_comb begin
        gap_next = proc_clock_en_o[0] ? 5'h01 : gap_reg + 5'h01;
        cln_next = cln_reg;
        if (chg) begin
            cln_next = 2'h0;
        end else if (proc_clock_en_o[0] && (cln_reg != 2'h3)) begin
            cln_next = cln_reg + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            for (int k = 0; k < 8; k++) sh_reg[k] <= 32'h0000_0000;
            gap_reg <= 5'h00;
            cln_reg <= 2'h0;
        end else begin
            if (reg_wr_i && hit) sh_reg[idx] <= reg_wdata_i & fmask(idx);
            gap_reg <= gap_next;
            cln_reg <= cln_next;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    // ==========================================================
    // Assertions
    chk_proc_gated_off: assert property (
        (proc_clock_en_o & ~(sh_reg[0][3:0] | $past(sh_reg[0][3:0])
         | $past(sh_reg[0][3:0], 2))) == 4'h0)
        else $error("processing enable while gate is closed");
    chk_bus_gate_follow: assert property (
        bus_clock_pass_o == $past(sh_reg[1][3:0]))
        else $error("bus clock pass differs from gate register");
    chk_reset_follow: assert property (
        reset_release_o == $past(sh_reg[2][3:0]))
        else $error("reset release differs from register");
    chk_div_spacing: assert property (
        proc_clock_en_o[0] && (cln_reg == 2'h3) |-> gap_reg == {1'b0, sh_reg[3][3:0]} + 5'h01)
        else $error("processing enable spacing wrong");
    chk_route_swap: assert property (
        {timing_controller_a_src_o, timing_controller_b_src_o}
        == ($past(sh_reg[4][0]) ? 2'b10 : 2'b01))
        else $error("controller sources wrong");
    chk_cmd_depth_map: assert property (
        {writeback_command_depth_o, second_compositor_command_depth_o,
         first_compositor_command_depth_o} == {$past(sh_reg[5][19:16]), $past(sh_reg[5][7:0])})
        else $error("command depth fields wrong");
    chk_di_select_map: assert property (
        {second_compositor_deinterlace_select_o, first_compositor_deinterlace_select_o}
        == {$past(sh_reg[7][4]), $past(sh_reg[7][0])})
        else $error("deinterlace selects wrong");
    chk_read_data: assert property (
        reg_rd_i |=> reg_rdata_o == $past(rd_exp))
        else $error("read data wrong");
    chk_read_idle_zero: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside its cycle");

    cov_unmapped_read: cover property (reg_rd_i && !hit);
    cov_route_swapped: cover property (timing_controller_a_src_o);
    cov_div_checked:   cover property (proc_clock_en_o[0] && (cln_reg == 2'h3));
endmodule : decrc_chk

bind decrc_top decrc_chk u_chk (
    .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .proc_clock_en_o, .bus_clock_pass_o, .reset_release_o,
    .timing_controller_a_src_o, .timing_controller_b_src_o,
    .first_compositor_command_depth_o, .second_compositor_command_depth_o,
    .writeback_command_depth_o, .first_compositor_deinterlace_select_o,
    .second_compositor_deinterlace_select_o
);

`default_nettype wire

/* File: decrc_units_model.sv */
// Sub-units behind the bank: each counts work steps on its processing enable.
// Assumes the same clock as the bank; a held unit loses its progress.
`timescale 1ns/10ps
`default_nettype none

module decrc_units_model (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [3:0]  tick_i,
    input  wire logic [3:0]  release_i,
    output logic      [15:0] work_cnt_o [4]
);
    // step only on enable while out of reset
    always_ff @(posedge core_clk_i) begin
        for (int u = 0; u < 4; u++) begin
            if (srst_i || !release_i[u]) work_cnt_o[u] <= 16'h0000;
            else if (tick_i[u]) work_cnt_o[u] <= work_cnt_o[u] + 16'h0001;
        end
    end
endmodule : decrc_units_model

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench of the display top control bank.
// Assumes the full variant and the plain strobe register port.
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import decrc_pkg::*;
;
    logic          core_clk_i;
    logic          srst_i;
    logic [11:0]   reg_addr_i;
    logic [31:0]   reg_wdata_i;
    logic          reg_wr_i;
    logic          reg_rd_i;
    logic [31:0]   reg_rdata_o;
    logic [31:0]   eng_addr_i;
    decrc_region_t eng_region_o;
    logic [3:0]    proc_clock_en_o;
    logic [3:0]    bus_clock_pass_o;
    logic [3:0]    reset_release_o;
    logic          timing_controller_a_src_o;
    logic          timing_controller_b_src_o;
    logic [3:0]    first_compositor_command_depth_o;
    logic [3:0]    second_compositor_command_depth_o;
    logic [3:0]    writeback_command_depth_o;
    logic          first_compositor_deinterlace_select_o;
    logic          second_compositor_deinterlace_select_o;
    logic [15:0]   cnt [4];
    int            err_count;
    int            checks;
    int            cyc;
    logic [11:0]   adr [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C};
    logic [31:0]   msk [7] = '{32'h0000_000F, 32'h0000_000F, 32'h0000_000F, 32'h0000_FFFF,
                               32'h0000_0001, 32'h000F_00FF, 32'h0000_0011};
    logic [31:0]   ea [10] = '{32'h0100_0000, 32'h0100_FFFF, 32'h0101_0004, 32'h0102_FFFF,
                               32'h0104_FFFF, 32'h0105_0000, 32'h0110_0000, 32'h012F_FFFF,
                               32'h0130_0000, 32'h00FF_FFFC};
    decrc_region_t er [10] = '{DECRC_REGION_TOP, DECRC_REGION_TOP, DECRC_REGION_WB,
                               DECRC_REGION_ROT, DECRC_REGION_DI, DECRC_REGION_NONE,
                               DECRC_REGION_FIRST, DECRC_REGION_SECOND, DECRC_REGION_NONE,
                               DECRC_REGION_NONE};

    decrc_top u_dut (
        .core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .eng_addr_i, .eng_region_o, .proc_clock_en_o, .bus_clock_pass_o, .reset_release_o,
        .timing_controller_a_src_o, .timing_controller_b_src_o,
        .first_compositor_command_depth_o, .second_compositor_command_depth_o,
        .writeback_command_depth_o, .first_compositor_deinterlace_select_o,
        .second_compositor_deinterlace_select_o
    );

    decrc_units_model u_units (
        .core_clk_i, .srst_i, .tick_i(proc_clock_en_o), .release_i(reset_release_o),
        .work_cnt_o(cnt)
    );

    // ==========================================================
    // Tasks
    task automatic test_done();
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge core_clk_i);
        check(reg_rdata_o, e);
    endtask : rdchk

    task automatic outs(input logic [31:0] e);
        repeat (2) @(posedge core_clk_i);
        check({8'h00, bus_clock_pass_o, reset_release_o, timing_controller_a_src_o,
               timing_controller_b_src_o, writeback_command_depth_o,
               second_compositor_command_depth_o, first_compositor_command_depth_o,
               second_compositor_deinterlace_select_o, first_compositor_deinterlace_select_o}, e);
    endtask : outs

    // Twelve cycles is a whole number of periods for every divide from 0 to 3.
    task automatic win(input logic [63:0] e);
        logic [15:0] s [4];
        repeat (4) @(posedge core_clk_i);
        for (int u = 0; u < 4; u++) s[u] = cnt[u];
        repeat (12) @(posedge core_clk_i);
        for (int u = 0; u < 4; u++) check({16'h0000, cnt[u] - s[u]}, {16'h0000, e[16*u +: 16]});
    endtask : win

    // ==========================================================
    // Clock, timeout and main sequence
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        srst_i = 1'b1;
        reg_addr_i = 12'h000;
        reg_wdata_i = 32'h0000_0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        eng_addr_i = 32'h0000_0000;
        err_count = 0;
        checks = 0;
        cyc = 0;
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
        for (int k = 0; k < 7; k++) rdchk(adr[k], 32'h0000_0000);
        outs(32'h0000_4000);
        for (int k = 0; k < 7; k++) wr(adr[k], 32'hFFFF_FFFF);
        for (int k = 0; k < 7; k++) rdchk(adr[k], msk[k]);
        outs(32'h00FF_BFFF);
        wr(12'h018, 32'hFFFF_FFFF);
        rdchk(12'h018, 32'h0000_0000);
        rdchk(12'h020, 32'h0000_0000);
        rdchk(12'h00E, 32'h0000_0000);
        wr(12'h004, 32'hFFFF_FFF5);
        wr(12'h008, 32'hFFFF_FFFA);
        wr(12'h010, 32'hFFFF_FFFE);
        wr(12'h014, 32'hFFFA_FF65);
        wr(12'h01C, 32'hFFFF_FFF0);
        outs(32'h005A_6996);
        wr(12'h00C, 32'hFFFF_3210);
        wr(12'h008, 32'h0000_000F);
        wr(12'h000, 32'h0000_000F);
        win({16'd3, 16'd4, 16'd6, 16'd12});
        wr(12'h000, 32'h0000_0000);
        win(64'h0);
        wr(12'h008, 32'h0000_000E);
        wr(12'h000, 32'h0000_000F);
        win({16'd3, 16'd4, 16'd6, 16'd0});
        for (int k = 0; k < 10; k++) begin
            @(posedge core_clk_i);
            eng_addr_i <= ea[k];
            repeat (2) @(posedge core_clk_i);
            check({29'h0, eng_region_o}, {29'h0, er[k]});
        end
        test_done();
    end
endmodule : tb_top

`default_nettype wire
